// file: design/tcm_device.sv
// transceiver control and monitor: two-wire slave and control registers
//
// Overview of operation
// - range bit picks high or low range
// - six-bit field picks assert threshold
// - hysteresis bit selects reduced hysteresis
// - fast bit shortens detection time
// - reset restores defaults; loads after init
// - transmit after init, enabled, pins low
// - transmit-disable pin cuts bias, keeps registers
// - ten-bit result split over two registers
// - host reads both result registers separately
// - three-bit field selects converter input
// - host sets monitor bits before converting
// - converter runs only with both enables
// - device is slave only, master clocks
// - answers address 0001000 plus direction
// - address, register, one data, stop
// - one data byte per transaction
// - idle bus leaves both lines high
// - repeated start begins new address phase
// - device pulls data low during acknowledge; host leaves it high after read data
// - no acknowledge leaves data line high
// - output-mode bit selects single-ended output
// - select bit swaps positive for negative
// - soft reset restores defaults, reads zero
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`include "tcm_regs.svh"
module tcm_device (
    tcm_if.dev bus,
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic transmit_disable_pin,
    input wire logic receive_disable_pin,
    input wire logic [9:0] conv_result,
    output logic regs_ready,
    output logic tx_ready,
    output logic chip_enable,
    output logic bias_current_on,
    output logic los_range_select,
    output logic [5:0] los_assert_level,
    output logic los_hysteresis_reduce,
    output logic los_fast_detect,
    output logic [2:0] converter_input_select,
    output logic converter_run,
    output logic photodiode_digital_monitor_select,
    output logic bias_digital_monitor_select,
    output logic single_ended_output_select,
    output logic negative_output_select,
    output logic pos_output_on,
    output logic neg_output_on
);
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers; stage 0 feeds stage 1 only
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] txd_s;
    logic [1:0] rxd_s;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            txd_s <= 2'h0;
            rxd_s <= 2'h0;
        end else begin
            scl_s <= {scl_s[1:0], bus.scl};
            sda_s <= {sda_s[1:0], bus.sda};
            txd_s <= {txd_s[0], transmit_disable_pin};
            rxd_s <= {rxd_s[0], receive_disable_pin};
        end
    end
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    assign scl_rise = scl_s[1] & ~scl_s[2];
    assign scl_fall = ~scl_s[1] & scl_s[2];
    assign start_seen = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    assign stop_seen = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

    ////////////////////////////////////////////////////////////////////
    // power-on timers
    logic [11:0] init_cnt_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            init_cnt_r <= 12'h000;
        end else if (init_cnt_r != 12'(`TCM_INIT2_CYC)) begin
            init_cnt_r <= init_cnt_r + 12'h001;
        end
    end
    logic init1_done;
    assign init1_done = init_cnt_r >= 12'(`TCM_INIT1_CYC);

    ////////////////////////////////////////////////////////////////////
    // serial slave
    tcm_pkg::tcm_slv_state_e state_r;
    logic [3:0] bit_r;
    tcm_pkg::tcm_byte_t shift_r;
    tcm_pkg::tcm_byte_t ptr_r;
    tcm_pkg::tcm_byte_t tx_r;
    tcm_pkg::tcm_byte_t rd_data;
    logic rw_r;
    logic sda_low_r;
    logic wr_fire_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= tcm_pkg::S_IDLE;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            tx_r <= 8'h00;
            rw_r <= 1'b0;
            sda_low_r <= 1'b0;
            wr_fire_r <= 1'b0;
        end else begin
            wr_fire_r <= 1'b0;
            if (start_seen) begin
                state_r <= tcm_pkg::S_ADDR;
                bit_r <= 4'h0;
                sda_low_r <= 1'b0;
            end else if (stop_seen) begin
                state_r <= tcm_pkg::S_IDLE;
                sda_low_r <= 1'b0;
            end else if (scl_rise) begin
                case (state_r)
                    tcm_pkg::S_ADDR, tcm_pkg::S_REG,
                    tcm_pkg::S_WDATA: begin
                        shift_r <= {shift_r[6:0], sda_s[1]};
                        bit_r <= bit_r + 4'h1;
                    end
                    tcm_pkg::S_RDATA: bit_r <= bit_r + 4'h1;
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state_r)
                    tcm_pkg::S_ADDR: if (bit_r == 4'h8) begin
                        bit_r <= 4'h0;
                        // unready or foreign address: stay released
                        if (shift_r[7:1] == `TCM_SLAVE_ADDR && init1_done)
                        begin
                            rw_r <= shift_r[0];
                            sda_low_r <= 1'b1;
                            state_r <= tcm_pkg::S_ADDR_ACK;
                        end else begin
                            state_r <= tcm_pkg::S_IGNORE;
                        end
                    end
                    tcm_pkg::S_ADDR_ACK: begin
                        sda_low_r <= 1'b0;
                        state_r <= tcm_pkg::S_REG;
                    end
                    tcm_pkg::S_REG: if (bit_r == 4'h8) begin
                        bit_r <= 4'h0;
                        ptr_r <= shift_r;
                        sda_low_r <= 1'b1;
                        state_r <= tcm_pkg::S_REG_ACK;
                    end
                    tcm_pkg::S_REG_ACK: begin
                        if (rw_r) begin
                            tx_r <= {rd_data[6:0], 1'b0};
                            sda_low_r <= ~rd_data[7];
                            state_r <= tcm_pkg::S_RDATA;
                        end else begin
                            sda_low_r <= 1'b0;
                            state_r <= tcm_pkg::S_WDATA;
                        end
                    end
                    tcm_pkg::S_WDATA: if (bit_r == 4'h8) begin
                        bit_r <= 4'h0;
                        wr_fire_r <= 1'b1;
                        sda_low_r <= 1'b1;
                        state_r <= tcm_pkg::S_WDATA_ACK;
                    end
                    tcm_pkg::S_WDATA_ACK: begin
                        sda_low_r <= 1'b0;
                        state_r <= tcm_pkg::S_IGNORE;
                    end
                    tcm_pkg::S_RDATA: begin
                        if (bit_r == 4'h8) begin
                            sda_low_r <= 1'b0;
                            state_r <= tcm_pkg::S_IGNORE;
                        end else begin
                            sda_low_r <= ~tx_r[7];
                            tx_r <= {tx_r[6:0], 1'b0};
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe_n = ~sda_low_r;

    ////////////////////////////////////////////////////////////////////
    // control registers, flip-flops indexed by offset
    logic [`TCM_NREG-1:0][7:0] reg_w;
    logic soft_rst;
    assign soft_rst = wr_fire_r && ptr_r == `TCM_REG_CORE0 &&
        (shift_r[`TCM_B_SOFT_RST] || shift_r[`TCM_B_GLOBAL_RST]);
    genvar gi;
    generate
        for (gi = 0; gi < `TCM_NREG; gi = gi + 1) begin : g_reg
            localparam logic [7:0] RST_V =
                (gi == 0) ? `TCM_CORE0_RST : `TCM_OTHER_RST;
            localparam logic [7:0] SC_M =
                (gi == 0) ? `TCM_CORE0_RWSC : 8'h00;
            tcm_pkg::tcm_byte_t q_r;
            always_ff @(posedge sys_clk) begin
                if (rst || soft_rst) begin
                    q_r <= RST_V;
                end else if (wr_fire_r && ptr_r == 8'(gi)) begin
                    q_r <= shift_r & ~SC_M;
                end
            end
            assign reg_w[gi] = q_r;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // converter result, held while the converter is stopped
    logic [9:0] result_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_r <= 10'h000;
        end else if (converter_run) begin
            result_r <= conv_result;
        end
    end
    always_comb begin
        rd_data = 8'h00;
        if (ptr_r < 8'(`TCM_NREG)) begin
            rd_data = reg_w[ptr_r[4:0]];
        end else if (ptr_r == `TCM_REG_RES_HI) begin
            rd_data = result_r[9:2];
        end else if (ptr_r == `TCM_REG_RES_LO) begin
            rd_data = {6'h00, result_r[1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control outputs
    logic tx_ready_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_ready_r <= 1'b0;
        end else begin
            tx_ready_r <= init_cnt_r == 12'(`TCM_INIT2_CYC) &&
                chip_enable && !txd_s[1] && !rxd_s[1];
        end
    end
    assign regs_ready = init1_done;
    assign tx_ready = tx_ready_r;
    assign chip_enable = reg_w[`TCM_REG_CORE0][`TCM_B_EN_CHIP];
    // pin gates the bias and tx_ready; settings survive and return on release
    assign bias_current_on = reg_w[`TCM_REG_BIASCTL][`TCM_B_BIAS_EN] &
        ~txd_s[1];
    assign los_range_select = reg_w[`TCM_REG_RX4][`TCM_B_RANGE];
    assign los_assert_level = reg_w[`TCM_REG_RX7][`TCM_B_LVL_HI:0];
    assign los_hysteresis_reduce = reg_w[`TCM_REG_RX6][`TCM_B_HYS];
    assign los_fast_detect = reg_w[`TCM_REG_RX5][`TCM_B_FAST];
    assign converter_input_select =
        reg_w[`TCM_REG_CONV][`TCM_B_SEL_HI:`TCM_B_SEL_LO];
    assign converter_run = reg_w[`TCM_REG_CONV][`TCM_B_OSC_EN] &
        reg_w[`TCM_REG_CONV][`TCM_B_CONV_EN];
    assign photodiode_digital_monitor_select =
        reg_w[`TCM_REG_MON][`TCM_B_PD_MON];
    assign bias_digital_monitor_select =
        reg_w[`TCM_REG_MON][`TCM_B_BIAS_MON];
    assign single_ended_output_select =
        reg_w[`TCM_REG_SINGLE_ENDED_OUTPUT_SELECT][`TCM_B_SE];
    assign negative_output_select = reg_w[`TCM_REG_SINGLE_ENDED_OUTPUT_SELECT][`TCM_B_NEG];
    assign pos_output_on = ~single_ended_output_select |
        ~negative_output_select;
    assign neg_output_on = ~single_ended_output_select |
        negative_output_select;
endmodule // tcm_device

// file: design/tcm_host.sv
// two-wire master that runs one single-byte transaction per command
`timescale 1ns/100ps
`include "tcm_regs.svh"
module tcm_host (
    tcm_if.host bus,
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    output logic [7:0] cpu_rdata
);
    ////////////////////////////////////////////////////////////////////
    // data line synchroniser
    logic [1:0] sda_s;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sda_s <= 2'h3;
        end else begin
            sda_s <= {sda_s[0], bus.sda};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // quarter-period timing
    tcm_pkg::tcm_mst_state_e state_r;
    logic [7:0] q_cnt_r;
    logic [1:0] q_r;
    logic tick;
    assign tick = q_cnt_r == 8'(`TCM_SCL_QTR_CYC - 1);
    always_ff @(posedge sys_clk) begin
        if (rst || state_r == tcm_pkg::M_IDLE) begin
            q_cnt_r <= 8'h00;
            q_r <= 2'h0;
        end else if (tick) begin
            q_cnt_r <= 8'h00;
            q_r <= q_r + 2'h1;
        end else begin
            q_cnt_r <= q_cnt_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command registers
    tcm_pkg::tcm_byte_t regaddr_r;
    tcm_pkg::tcm_byte_t wdata_r;
    tcm_pkg::tcm_byte_t rdata_r;
    logic rw_r;
    logic nack_r;
    logic done_r;
    logic go;
    logic done_set;
    assign go = cpu_wr && cpu_addr == `TCM_H_CTRL &&
        state_r == tcm_pkg::M_IDLE &&
        (cpu_wdata[`TCM_H_GO_WR] || cpu_wdata[`TCM_H_GO_RD]);
    assign done_set = state_r == tcm_pkg::M_STOP && tick && q_r == 2'h3;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regaddr_r <= 8'h00;
            wdata_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            if (cpu_wr && cpu_addr == `TCM_H_REGADDR) begin
                regaddr_r <= cpu_wdata;
            end
            if (cpu_wr && cpu_addr == `TCM_H_WDATA) begin
                wdata_r <= cpu_wdata;
            end
            // a finish in the clearing cycle keeps the flag set
            if (done_set) begin
                done_r <= 1'b1;
            end else if (cpu_wr && cpu_addr == `TCM_H_STATUS &&
                         cpu_wdata[`TCM_H_DONE]) begin
                done_r <= 1'b0;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst || !cpu_rd) begin
            cpu_rdata <= 8'h00;
        end else begin
            case (cpu_addr)
                `TCM_H_REGADDR: cpu_rdata <= regaddr_r;
                `TCM_H_WDATA: cpu_rdata <= wdata_r;
                `TCM_H_STATUS: cpu_rdata <= {5'h00, done_r, nack_r,
                    state_r != tcm_pkg::M_IDLE};
                `TCM_H_RDATA: cpu_rdata <= rdata_r;
                default: cpu_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bit engine
    logic [3:0] bit_r;
    logic [1:0] byte_r;
    logic scl_low_r;
    logic sda_low_r;
    logic ack_hi_r;
    tcm_pkg::tcm_byte_t cur_byte;
    always_comb begin
        case (byte_r)
            2'h0: cur_byte = {`TCM_SLAVE_ADDR, rw_r};
            2'h1: cur_byte = regaddr_r;
            default: cur_byte = rw_r ? 8'hff : wdata_r;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= tcm_pkg::M_IDLE;
            bit_r <= 4'h0;
            byte_r <= 2'h0;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            ack_hi_r <= 1'b0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            case (state_r)
                tcm_pkg::M_IDLE: begin
                    scl_low_r <= 1'b0;
                    sda_low_r <= 1'b0;
                    if (go) begin
                        rw_r <= cpu_wdata[`TCM_H_GO_RD];
                        nack_r <= 1'b0;
                        state_r <= tcm_pkg::M_START;
                    end
                end
                tcm_pkg::M_START: if (tick) begin
                    if (q_r == 2'h0) sda_low_r <= 1'b1;
                    if (q_r == 2'h1) scl_low_r <= 1'b1;
                    if (q_r == 2'h3) begin
                        bit_r <= 4'h0;
                        byte_r <= 2'h0;
                        state_r <= tcm_pkg::M_BIT;
                    end
                end
                tcm_pkg::M_BIT: if (tick) begin
                    case (q_r)
                        // acknowledge bit is always released here
                        2'h0: sda_low_r <= bit_r != 4'h8 &&
                            !cur_byte[3'(4'h7 - bit_r)];
                        2'h1: scl_low_r <= 1'b0;
                        2'h2: begin
                            ack_hi_r <= sda_s[1];
                            if (byte_r == 2'h2 && rw_r && bit_r != 4'h8) begin
                                rdata_r <= {rdata_r[6:0], sda_s[1]};
                            end
                        end
                        default: begin
                            scl_low_r <= 1'b1;
                            if (bit_r != 4'h8) begin
                                bit_r <= bit_r + 4'h1;
                            end else if (ack_hi_r && !(byte_r == 2'h2 && rw_r))
                            begin
                                nack_r <= 1'b1;
                                state_r <= tcm_pkg::M_STOP;
                            end else if (byte_r == 2'h2) begin
                                state_r <= tcm_pkg::M_STOP;
                            end else begin
                                bit_r <= 4'h0;
                                byte_r <= byte_r + 2'h1;
                            end
                        end
                    endcase
                end
                tcm_pkg::M_STOP: if (tick) begin
                    if (q_r == 2'h0) sda_low_r <= 1'b1;
                    if (q_r == 2'h1) scl_low_r <= 1'b0;
                    if (q_r == 2'h2) sda_low_r <= 1'b0;
                    if (q_r == 2'h3) state_r <= tcm_pkg::M_IDLE;
                end
                default: state_r <= tcm_pkg::M_IDLE;
            endcase
        end
    end
    assign bus.host_scl_o = 1'b0;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_scl_oe_n = ~scl_low_r;
    assign bus.host_sda_oe_n = ~sda_low_r;
endmodule // tcm_host

// file: design/tcm_if.sv
// two-wire bus between host and device, with pull-ups modelled
`timescale 1ns/100ps
interface tcm_if;
    logic scl;
    logic sda;
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    // released lines float high through the pull-ups
    assign scl = host_scl_oe_n ? 1'b1 : host_scl_o;
    assign sda = (host_sda_oe_n ? 1'b1 : host_sda_o) &
                 (dev_sda_oe_n ? 1'b1 : dev_sda_o);
    modport dev (input scl, input sda, output dev_sda_o,
                 output dev_sda_oe_n);
    modport host (input scl, input sda, output host_scl_o,
                  output host_scl_oe_n, output host_sda_o,
                  output host_sda_oe_n);
endinterface

// file: design/tcm_pkg.sv
// shared types of the transceiver control block
package tcm_pkg;
    typedef logic [7:0] tcm_byte_t;
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_REG, S_REG_ACK,
        S_WDATA, S_WDATA_ACK, S_RDATA, S_IGNORE
    } tcm_slv_state_e;
    typedef enum logic [1:0] {
        M_IDLE, M_START, M_BIT, M_STOP
    } tcm_mst_state_e;
endpackage

// file: design/tcm_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef TCM_REGS_SVH
`define TCM_REGS_SVH
`define TCM_SLAVE_ADDR 7'h08
`define TCM_NREG 32
`define TCM_REG_CORE0 8'h00
`define TCM_REG_BIASCTL 8'h01
`define TCM_REG_CONV 8'h03
`define TCM_REG_RX4 8'h04
`define TCM_REG_RX5 8'h05
`define TCM_REG_RX6 8'h06
`define TCM_REG_RX7 8'h07
`define TCM_REG_SINGLE_ENDED_OUTPUT_SELECT 8'h0d
`define TCM_REG_MON 8'h10
`define TCM_REG_RES_HI 8'h28
`define TCM_REG_RES_LO 8'h29
`define TCM_CORE0_RST 8'h41
`define TCM_OTHER_RST 8'h00
`define TCM_CORE0_RWSC 8'h86
`define TCM_B_EN_CHIP 0
`define TCM_B_SOFT_RST 1
`define TCM_B_GLOBAL_RST 7
`define TCM_B_BIAS_EN 2
`define TCM_B_SEL_HI 2
`define TCM_B_SEL_LO 0
`define TCM_B_OSC_EN 6
`define TCM_B_CONV_EN 7
`define TCM_B_RANGE 0
`define TCM_B_FAST 3
`define TCM_B_HYS 7
`define TCM_B_LVL_HI 5
`define TCM_B_SE 6
`define TCM_B_NEG 7
`define TCM_B_PD_MON 6
`define TCM_B_BIAS_MON 5
`define TCM_CLK_MHZ 10
`define TCM_INIT1_US 50
`define TCM_INIT1_CYC (`TCM_INIT1_US * `TCM_CLK_MHZ)
`define TCM_INIT2_US 200
`define TCM_INIT2_CYC (`TCM_INIT2_US * `TCM_CLK_MHZ)
`define TCM_SCL_QTR_NS 1000
`define TCM_SCL_QTR_CYC ((`TCM_SCL_QTR_NS * `TCM_CLK_MHZ + 999) / 1000)
`define TCM_H_REGADDR 3'h0
`define TCM_H_WDATA 3'h1
`define TCM_H_CTRL 3'h2
`define TCM_H_STATUS 3'h3
`define TCM_H_RDATA 3'h4
`define TCM_H_GO_WR 0
`define TCM_H_GO_RD 1
`define TCM_H_BUSY 0
`define TCM_H_NACK 1
`define TCM_H_DONE 2
`endif

// file: verif/tcm_assertions.sv
// concurrent checks on the two-wire bus between host and device
`timescale 1ns/100ps
module tcm_assertions (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic host_scl_oe_n,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_oe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic scl_q, sda_q, start_ev, stop_ev;
    logic [5:0] edge_cnt_r;
    assign start_ev = scl && scl_q && sda_q && !sda;
    assign stop_ev = scl && scl_q && !sda_q && sda;
    always_ff @(posedge sys_clk) begin
        scl_q <= scl;
        sda_q <= sda;
    end
    // saturating, so a stuck bus cannot wrap back to a legal count
    always_ff @(posedge sys_clk) begin
        if (rst || start_ev)
            edge_cnt_r <= 6'h00;
        else if (scl && !scl_q && edge_cnt_r != 6'h3f)
            edge_cnt_r <= edge_cnt_r + 6'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    AST_IDLE_RST: assert property (disable iff (1'b0) rst |=>
        host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n)
        else $error("bus line pulled during reset");
    AST_NO_DEV_START: assert property (start_ev |-> !host_sda_oe_n)
        else $error("start not made by host");
    AST_NO_DEV_STOP: assert property (stop_ev |-> $past(dev_sda_oe_n))
        else $error("stop while device held data");
    AST_DEV_STABLE: assert property (scl && scl_q |->
        $stable(dev_sda_oe_n)) else $error("device data moved at high clock");
    AST_ACK_RELEASE: assert property (!dev_sda_oe_n && scl |->
        host_sda_oe_n) else $error("host held data while device drove");
    AST_SCL_HIGH: assert property ($rose(scl) |-> scl[*8])
        else $error("clock high phase too short");
    AST_SCL_LOW: assert property ($fell(scl) |-> (!scl)[*8])
        else $error("clock low phase too short");
    // 27 bits plus the stop rise, or an abort after the address byte
    AST_BIT_COUNT: assert property (stop_ev |->
        edge_cnt_r == 6'h1c || edge_cnt_r == 6'h0a)
        else $error("wrong clock count in transaction");
    AST_IDLE_STOP: assert property (stop_ev |=> (scl && sda)[*3])
        else $error("bus not idle after stop");
endmodule // tcm_assertions

// file: verif/testbench.sv
// self-checking bench: host and device joined on one two-wire bus
`timescale 1ns/100ps
module testbench;
    logic sys_clk = 1'b0, rst = 1'b1, cpu_wr = 1'b0, cpu_rd = 1'b0;
    logic tx_pin = 1'b0, rx_pin = 1'b0;
    logic [2:0] cpu_addr = 3'h0;
    logic [7:0] cpu_wdata = 8'h00, cpu_rdata, rd_v;
    logic [9:0] conv = 10'h2a5;
    logic regs_ready, tx_ready, chip_en, bias_on, lrs, lhr, lfd, run;
    logic pdm, bdm, se, neg, pos_on, neg_on;
    logic [5:0] lal;
    logic [2:0] cis;
    logic [18:0] ctl;
    // monitor selects go in before the converter is started
    logic [7:0] ra_t [8] = '{8'h0d, 8'h04, 8'h07, 8'h06, 8'h05, 8'h10,
        8'h03, 8'h0d};
    logic [7:0] vd_t [8] = '{8'h40, 8'h01, 8'h3f, 8'h80, 8'h08, 8'h60,
        8'hc3, 8'hc0};
    int fail_count = 0, samples_checked = 0;
    assign ctl = {lrs, lal, lhr, lfd, cis, run, pdm, bdm, se, neg, pos_on,
        neg_on};
    always #50 sys_clk = ~sys_clk;
    tcm_if bus ();
    tcm_host tcm_host_inst (.bus(bus), .sys_clk(sys_clk), .rst(rst),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata));
    tcm_device tcm_device_inst (.bus(bus), .sys_clk(sys_clk), .rst(rst),
        .transmit_disable_pin(tx_pin), .receive_disable_pin(rx_pin),
        .conv_result(conv), .regs_ready(regs_ready), .tx_ready(tx_ready),
        .chip_enable(chip_en), .bias_current_on(bias_on),
        .los_range_select(lrs), .los_assert_level(lal),
        .los_hysteresis_reduce(lhr), .los_fast_detect(lfd),
        .converter_input_select(cis), .converter_run(run),
        .photodiode_digital_monitor_select(pdm),
        .bias_digital_monitor_select(bdm),
        .single_ended_output_select(se), .negative_output_select(neg),
        .pos_output_on(pos_on), .neg_output_on(neg_on));
    tcm_assertions tcm_assertions_inst (.sys_clk(sys_clk), .rst(rst),
        .scl(bus.scl), .sda(bus.sda), .host_scl_oe_n(bus.host_scl_oe_n),
        .host_sda_oe_n(bus.host_sda_oe_n), .dev_sda_oe_n(bus.dev_sda_oe_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // a gap cycle after each strobe keeps one assignment per time step
    task automatic hw(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= 1'b1;
        @(posedge sys_clk);
        cpu_wr <= 1'b0;
    endtask
    task automatic hr(input logic [2:0] a, output logic [7:0] q);
        @(posedge sys_clk);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge sys_clk);
        cpu_rd <= 1'b0;
        #1 q = cpu_rdata;
    endtask
    // nk of x means the acknowledge outcome is not judged
    task automatic xfer(input logic w, input logic [7:0] ra,
        input logic [7:0] d, input logic nk, output logic [7:0] q);
        logic [7:0] st;
        st = 8'h00;
        hw(3'h0, ra);
        hw(3'h1, d);
        hw(3'h2, w ? 8'h01 : 8'h02);
        for (int i = 0; i < 2000 && st[2] !== 1'b1; i++)
            hr(3'h3, st);
        if (st[2] !== 1'b1) begin
            fail_count++;
            summarize();
        end
        if (nk !== 1'bx)
            chk(st[1], nk);
        hw(3'h3, 8'h04);
        hr(3'h4, q);
    endtask
    task automatic rchk(input logic [7:0] ra, input logic [7:0] e);
        xfer(1'b0, ra, 8'h00, 1'b0, rd_v);
        chk(rd_v, e);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk({ctl, chip_en, tx_ready, bias_on}, {19'h00003, 3'h4});
        xfer(1'b1, 8'h04, 8'h01, 1'b1, rd_v);
        for (int i = 0; i < 1000 && regs_ready !== 1'b1; i++)
            @(posedge sys_clk);
        #1 chk(regs_ready, 1'b1);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, ra_t[i], vd_t[i], 1'b0, rd_v);
            rchk(ra_t[i], vd_t[i]);
            if (i == 0)
                chk({pos_on, neg_on}, 2'h2);
        end
        chk(ctl, 19'h7fdfd);
        $display("control test done");
        rchk(8'h28, 8'ha9);
        rchk(8'h29, 8'h01);
        xfer(1'b1, 8'h28, 8'h00, 1'bx, rd_v);
        rchk(8'h28, 8'ha9);
        $display("converter test done");
        xfer(1'b1, 8'h00, 8'h03, 1'b0, rd_v);
        rchk(8'h00, 8'h41);
        rchk(8'h07, 8'h00);
        chk(ctl, 19'h00003);
        $display("soft reset test done");
        xfer(1'b1, 8'h01, 8'h04, 1'b0, rd_v);
        chk({tx_ready, bias_on, chip_en}, 3'h7);
        @(posedge sys_clk);
        tx_pin <= 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 chk({tx_ready, bias_on}, 2'h0);
        rchk(8'h01, 8'h04);
        @(posedge sys_clk);
        tx_pin <= 1'b0;
        rx_pin <= 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 chk({tx_ready, bias_on}, 2'h1);
        @(posedge sys_clk);
        rx_pin <= 1'b0;
        xfer(1'b1, 8'h00, 8'h00, 1'b0, rd_v);
        chk({tx_ready, chip_en}, 2'h0);
        $display("transmit test done");
        summarize();
    end
endmodule // testbench
